//--- core/sfcfe_consts.svh
// constants of the serial flash command front end: opcodes, status layout,
// reset values, identifier bytes and timing figures
// assumes a 125 MHz mclk; the includer supplies the time base
// Overview of operation
// [R1] arm opcode at byte boundary sets latch
// [R2] host arms latch before every write
// [R3] disarm opcode at byte boundary clears latch
// [R4] latch cleared at reset and cycle end
// [R5] status read accepted even while busy
// [R6] status byte repeats until deselect
// [R7] busy bit follows any write cycle
// [R8] latch clear rejects all write instructions
// [R9] area bits written only by status write
// [R10] whole clear only with area bits zero
// [R11] status bits five and six read zero
// [R12] lock bit plus low pin blocks status write
// [R13] status write is opcode plus one byte
// [R14] status write keeps bits six five one zero
// [R15] status write runs timed busy cycle
// [R16] read takes opcode and three address bytes
// [R17] read address increments and wraps around
// [R18] read rejected during busy, deselect ends it
// [R19] fast read adds one dummy byte
// [R20] all bytes travel most significant first
// [R21] wake opcode returns part code repeatedly
// [R22] id read alternates maker and part code
// [R23] write instructions need byte aligned deselect
// [R24] array access ignored while cycle runs
// [R25] status layout busy latch area lock
`ifndef SFCFE_CONSTS_SVH
`define SFCFE_CONSTS_SVH

`define SFCFE_OP_ARM 8'h06
`define SFCFE_OP_DISARM 8'h04
`define SFCFE_OP_STAT_RD 8'h05
`define SFCFE_OP_STAT_WR 8'h01
`define SFCFE_OP_READ 8'h03
`define SFCFE_OP_FAST 8'h0b
`define SFCFE_OP_PAGE 8'h02
`define SFCFE_OP_SECTOR 8'hd8
`define SFCFE_OP_WHOLE 8'hc7
`define SFCFE_OP_WAKE_ID 8'hab
`define SFCFE_OP_MFG_ID 8'h90

// status bit positions
`define SFCFE_ST_BUSY 0
`define SFCFE_ST_WEL 1
`define SFCFE_ST_AREA_LO 2
`define SFCFE_ST_AREA_HI 3
`define SFCFE_ST_LOCK 7

// non-volatile bits come up clear, no storage model behind them
`define SFCFE_AREA_RESET 2'h0
`define SFCFE_LOCK_RESET 1'h0

// protected area starts for the two partial settings
`define SFCFE_AREA_HALF 24'h020000
`define SFCFE_AREA_QUART 24'h030000
`define SFCFE_ARRAY_TOP 24'h03ffff

// identifier bytes: values arbitrary
`define SFCFE_PART_CODE 8'h5a
`define SFCFE_MAKER_CODE 8'ha5
`define SFCFE_UNDERRUN 8'hff

// timing
`define SFCFE_CLK_NS 8
`define SFCFE_TW_NS 5000000

`endif

//--- core/sfcfe_pkg.sv
// types of the serial flash command front end
// assumes nothing beyond a SystemVerilog compiler
package sfcfe_pkg;

    // what the serial output is streaming, one-hot
    typedef enum logic [3:0] {
        OUT_NONE = 4'b0001,
        OUT_STATUS = 4'b0010,
        OUT_ID = 4'b0100,
        OUT_ARRAY = 4'b1000
    } sfcfe_out_e_t;

    // start pulses handed to the program and erase neighbours
    typedef struct packed {
        logic page;
        logic sector;
        logic whole;
        logic [23:0] addr;
    } sfcfe_launch_t;

    // fetch request towards the array
    typedef struct packed {
        logic valid;
        logic [23:0] addr;
    } sfcfe_fetch_t;

endpackage

//--- core/sfcfe_front_end.sv
// serial flash command front end: spi pin sampling, instruction decode,
// status register, timed status write and prefetching array reads
// assumes an array that answers a fetch in a few mclk cycles and sclk at
// least eight times slower than mclk
`timescale 1ns/1ns
`include "sfcfe_consts.svh"

// small first-word-fall-through buffer between array and serial shifter
module sfcfe_fifo
    import sfcfe_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    input wire logic flush,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
            $error("depth must be a power of two of at least two");
        end
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } sfcfe_fifo_state_t;

    sfcfe_fifo_state_t s_r, s_nxt;
    logic push, pop;

    assign inReady = (s_r.cnt != (PW+1)'(DEPTH));
    assign outValid = (s_r.cnt != '0);
    assign outData = s_r.mem[s_r.rp];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // pointer and count update, flush drops everything held
    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = inData;
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
        if (flush) begin
            s_nxt.wp = '0;
            s_nxt.rp = '0;
            s_nxt.cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstN) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

module sfcfe_front_end
    import sfcfe_pkg::*;
#(
    parameter int TW_NS = `SFCFE_TW_NS,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // spi pins, asynchronous to mclk
    input wire logic chipSelN,
    input wire logic sclk,
    input wire logic serialIn,
    input wire logic writeProtectN,
    output logic serialOut_r,
    output logic serialOutEn_r,
    // array fetch path, on mclk
    output sfcfe_fetch_t fetch_r,
    input wire logic arrDataValid,
    input wire logic [7:0] arrData,
    // program and erase neighbours
    input wire logic arrayBusy,
    input wire logic arrayOpDone,
    output sfcfe_launch_t launch_r,
    // status byte as seen by the host
    output logic [7:0] statusByte_r
);
    // status write cycle in mclk cycles, rounded up
    localparam int TW_CYC = (TW_NS + `SFCFE_CLK_NS - 1) / `SFCFE_CLK_NS;

    initial begin
        if (TW_CYC < 1 || FIFO_DEPTH < 2) begin
            $error("status write time or buffer depth out of range");
        end
    end

    typedef struct packed {
        logic [2:0] csS;        // chip select synchroniser plus history
        logic [2:0] sclkS;      // serial clock synchroniser plus history
        logic [1:0] sdiS;       // serial data synchroniser
        logic [1:0] wpS;        // write protect synchroniser
        logic [7:0] rx;         // incoming byte, msb first
        logic [2:0] bitCnt;     // bits of the current byte
        logic [2:0] byteCnt;    // whole bytes seen, saturating
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [7:0] wrData;     // data byte of a status write
        sfcfe_out_e_t outSrc;
        logic [7:0] tx;
        logic [2:0] txBits;     // bits still to send of tx
        logic idAlt;            // next id byte is the maker code
        logic lock;
        logic [1:0] area;
        logic write_enable_latch;
        logic wsrBusy;
        logic [31:0] wsrCnt;
        logic [23:0] fetchAddr;
        logic fetchPending;
        logic sdo;
        logic sdoEn;
        sfcfe_fetch_t fetch;
        sfcfe_launch_t launch;
        logic [7:0] status;
    } sfcfe_state_t;

    sfcfe_state_t s_r, s_nxt;

    logic fifoInReady, fifoOutValid, fifoPop, fifoPush, deselEdge;
    logic [7:0] fifoData;

    // true when the address falls in the area guarded by the area bits
    function automatic logic isGuarded(input logic [1:0] ar, input logic [23:0] a);
        logic g;
        g = 1'b0;
        unique case (ar)
            2'b11: g = 1'b1;
            2'b10: g = (a >= `SFCFE_AREA_HALF);
            2'b01: g = (a >= `SFCFE_AREA_QUART);
            default: g = 1'b0;
        endcase
        return g;
    endfunction

    // read data waits here so the shifter never stalls on array latency
    sfcfe_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rstN(rst_n),
        .flush(deselEdge),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .inData(arrData),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    // whole front end: sampling, decode, status and serial output
    always_comb begin
        logic sel, rise, fall, busy, byteDone, hwLock, aligned;
        logic [7:0] rxN, ld;
        logic [2:0] bitN;
        s_nxt = s_r;
        fifoPop = 1'b0;
        ld = 8'h00;
        // data and write protect are read at the second flop; chip select and sclk also at the third
        s_nxt.csS = {s_r.csS[1:0], chipSelN};
        s_nxt.sclkS = {s_r.sclkS[1:0], sclk};
        s_nxt.sdiS = {s_r.sdiS[0], serialIn};
        s_nxt.wpS = {s_r.wpS[0], writeProtectN};
        sel = !s_r.csS[1];
        deselEdge = s_r.csS[1] & !s_r.csS[2];
        rise = sel & s_r.sclkS[1] & !s_r.sclkS[2];
        fall = sel & !s_r.sclkS[1] & s_r.sclkS[2];
        busy = s_r.wsrBusy | arrayBusy;
        hwLock = s_r.lock & !s_r.wpS[1];
        aligned = (s_r.bitCnt == 3'h0);
        rxN = {s_r.rx[6:0], s_r.sdiS[1]};  // see [R20]
        bitN = s_r.bitCnt + 3'h1;
        byteDone = rise & (bitN == 3'h0);
        fifoPush = arrDataValid & s_r.fetchPending & (s_r.outSrc == OUT_ARRAY);
        s_nxt.launch.page = 1'b0;
        s_nxt.launch.sector = 1'b0;
        s_nxt.launch.whole = 1'b0;
        s_nxt.fetch.valid = 1'b0;

        // input shifting on sampled rising sclk
        if (rise) begin
            s_nxt.rx = rxN;
            s_nxt.bitCnt = bitN;
        end
        if (byteDone) begin
            if (s_r.byteCnt != 3'h7) begin
                s_nxt.byteCnt = s_r.byteCnt + 3'h1;
            end
            unique case (s_r.byteCnt)
                3'h0: begin
                    s_nxt.opcode = rxN;
                    if (rxN == `SFCFE_OP_STAT_RD) begin
                        s_nxt.outSrc = OUT_STATUS;  // see [R5]
                    end
                end
                3'h1, 3'h2, 3'h3: begin
                    if (s_r.byteCnt == 3'h1) begin
                        s_nxt.wrData = rxN;  // see [R13]
                    end
                    s_nxt.addr = {s_r.addr[15:0], rxN};  // see [R16]
                    if (s_r.byteCnt == 3'h3) begin
                        if (s_r.opcode == `SFCFE_OP_READ && !busy) begin
                            s_nxt.outSrc = OUT_ARRAY;  // see [R16] [R18] [R24]
                            s_nxt.fetchAddr = {s_r.addr[15:0], rxN};
                        end
                        if (s_r.opcode == `SFCFE_OP_WAKE_ID) begin
                            s_nxt.outSrc = OUT_ID;  // see [R21]
                            s_nxt.idAlt = 1'b0;
                        end
                        if (s_r.opcode == `SFCFE_OP_MFG_ID) begin
                            s_nxt.outSrc = OUT_ID;
                            s_nxt.idAlt = (rxN == 8'h00);  // see [R22]
                        end
                    end
                end
                3'h4: begin
                    if (s_r.opcode == `SFCFE_OP_FAST && !busy) begin
                        s_nxt.outSrc = OUT_ARRAY;  // see [R19] [R24]
                        s_nxt.fetchAddr = s_r.addr;
                    end
                end
                default: begin
                    // data bytes of long instructions are not decoded here
                end
            endcase
        end

        // serial output, one bit per sampled falling sclk
        if (fall && s_r.outSrc != OUT_NONE) begin
            if (s_r.txBits == 3'h0) begin
                unique case (s_r.outSrc)
                    OUT_STATUS: ld = s_r.status;  // see [R6]
                    OUT_ID: begin
                        ld = s_r.idAlt ? `SFCFE_MAKER_CODE : `SFCFE_PART_CODE;
                        if (s_r.opcode == `SFCFE_OP_MFG_ID) begin
                            s_nxt.idAlt = !s_r.idAlt;  // see [R22]
                        end
                    end
                    OUT_ARRAY: begin
                        ld = fifoOutValid ? fifoData : `SFCFE_UNDERRUN;
                        fifoPop = fifoOutValid;
                    end
                    default: ld = 8'h00;
                endcase
                s_nxt.sdo = ld[7];  // see [R20]
                s_nxt.tx = {ld[6:0], 1'b0};
                s_nxt.txBits = 3'h7;
            end else begin
                s_nxt.sdo = s_r.tx[7];
                s_nxt.tx = {s_r.tx[6:0], 1'b0};
                s_nxt.txBits = s_r.txBits - 3'h1;
            end
        end
        s_nxt.sdoEn = sel & (s_nxt.outSrc != OUT_NONE);

        // prefetch: one fetch in flight, only while the buffer has room
        if (arrDataValid) begin
            s_nxt.fetchPending = 1'b0;
        end
        if (s_r.outSrc == OUT_ARRAY && !s_r.fetchPending && fifoInReady && sel) begin
            s_nxt.fetch.valid = 1'b1;
            s_nxt.fetch.addr = s_r.fetchAddr;
            s_nxt.fetchPending = 1'b1;
            // step and wrap to zero past the top  see [R17]
            s_nxt.fetchAddr = (s_r.fetchAddr == `SFCFE_ARRAY_TOP) ? 24'h000000
                : s_r.fetchAddr + 24'h000001;
        end

        // timed status write cycle
        if (s_r.wsrBusy) begin
            if (s_r.wsrCnt == 32'h00000001) begin
                s_nxt.wsrBusy = 1'b0;  // see [R15]
                s_nxt.write_enable_latch = 1'b0;      // see [R4]
            end
            s_nxt.wsrCnt = s_r.wsrCnt - 32'h00000001;
        end
        if (arrayOpDone) begin
            s_nxt.write_enable_latch = 1'b0;  // see [R4]
        end

        // deselect: execute write class instructions, end any read
        if (deselEdge) begin
            if (aligned) begin  // see [R23]
                if (s_r.opcode == `SFCFE_OP_ARM && s_r.byteCnt == 3'h1) begin
                    s_nxt.write_enable_latch = 1'b1;  // see [R1]
                end
                if (s_r.opcode == `SFCFE_OP_DISARM && s_r.byteCnt == 3'h1) begin
                    s_nxt.write_enable_latch = 1'b0;  // see [R3]
                end
                // status write: exact length, armed, idle and not locked
                if (s_r.opcode == `SFCFE_OP_STAT_WR && s_r.byteCnt == 3'h2
                    && s_r.write_enable_latch && !busy && !hwLock) begin  // see [R8] [R12] [R13]
                    s_nxt.lock = s_r.wrData[`SFCFE_ST_LOCK];  // see [R9] [R14]
                    s_nxt.area = s_r.wrData[`SFCFE_ST_AREA_HI:`SFCFE_ST_AREA_LO];
                    s_nxt.wsrBusy = 1'b1;  // see [R15]
                    s_nxt.wsrCnt = 32'(TW_CYC);
                end
                if (s_r.opcode == `SFCFE_OP_WHOLE && s_r.byteCnt == 3'h1
                    && s_r.write_enable_latch && !busy && s_r.area == 2'b00) begin
                    s_nxt.launch.whole = 1'b1;  // see [R8] [R10]
                end
                if (s_r.opcode == `SFCFE_OP_SECTOR && s_r.byteCnt == 3'h4
                    && s_r.write_enable_latch && !busy && !isGuarded(s_r.area, s_r.addr)) begin
                    s_nxt.launch.sector = 1'b1;  // see [R8] [R9]
                end
                if (s_r.opcode == `SFCFE_OP_PAGE && s_r.byteCnt >= 3'h5
                    && s_r.write_enable_latch && !busy && !isGuarded(s_r.area, s_r.addr)) begin
                    s_nxt.launch.page = 1'b1;  // see [R8] [R9]
                end
                s_nxt.launch.addr = s_r.addr;
            end
            // deselect always ends parsing and output  see [R18]
            s_nxt.bitCnt = 3'h0;
            s_nxt.byteCnt = 3'h0;
            s_nxt.opcode = 8'h00;
            s_nxt.outSrc = OUT_NONE;
            s_nxt.txBits = 3'h0;
            s_nxt.sdoEn = 1'b0;
        end

        // reserved bits five, six and four read zero  see [R11] [R25]
        s_nxt.status = {s_nxt.lock, 3'b000, s_nxt.area, s_nxt.write_enable_latch,
            s_nxt.wsrBusy | arrayBusy};  // see [R7]
    end

    // single state register, synchronous reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.csS <= 3'b111;
            s_r.sclkS <= 3'b000;
            s_r.wpS <= 2'b11;
            s_r.outSrc <= OUT_NONE;
            s_r.area <= `SFCFE_AREA_RESET;
            s_r.lock <= `SFCFE_LOCK_RESET;
            s_r.write_enable_latch <= 1'b0;  // see [R4]
        end else begin
            s_r <= s_nxt;
        end
    end

    assign serialOut_r = s_r.sdo;
    assign serialOutEn_r = s_r.sdoEn;
    assign fetch_r = s_r.fetch;
    assign launch_r = s_r.launch;
    assign statusByte_r = s_r.status;
endmodule

//--- testbench/sfcfe_host_model.sv
// host spi controller model: mode 0 frames, msb first
// assumes the bench calls xfer one frame at a time
`timescale 1ns/1ns
module sfcfe_host_model (
    // spi pins towards the device
    output logic chipSelN,
    output logic sclk,
    output logic serialIn,
    input wire logic serialOut_r,
    input wire logic serialOutEn_r
);
    // deselected, clock parked low
    initial begin
        chipSelN = 1'b1;
        sclk = 1'b0;
        serialIn = 1'b1;
    end

    // one frame of nbits clocks; rx bits read x while not driven
    task automatic xfer(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
        rx = '1;
        chipSelN = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            serialIn = tx[63-i];
            #62 sclk = 1'b1;
            rx[63-i] = serialOutEn_r ? serialOut_r : 1'bx;
            #63 sclk = 1'b0;
        end
        // deselect right after the last clock, never mid-byte unless asked
        #63 chipSelN = 1'b1;
        // released line flips so a stale value cannot pass
        serialIn = ~serialIn;
        #125;
    endtask
endmodule

//--- testbench/sfcfe_front_end_properties.sv
// timing checks of the front end status, launch and output enable
// assumes binding to sfcfe_front_end, watching its ports only
`timescale 1ns/1ns
module sfcfe_front_end_properties
    import sfcfe_pkg::*;
#(
    parameter int TW_NS = 1000
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // spi side
    input wire logic chipSelN,
    input wire logic serialOutEn_r,
    // neighbours and status
    input wire logic arrayBusy,
    input wire logic arrayOpDone,
    input wire sfcfe_launch_t launch_r,
    input wire logic [7:0] statusByte_r
);
    localparam int TW_CYC = (TW_NS + 7) / 8; // timed cycle length
    logic [10:0] busyRun_r; // cycles the busy bit has stood

    // count the busy run; long enough for the scaled timed cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busyRun_r <= '0;
        end else if (statusByte_r[0]) begin
            busyRun_r <= busyRun_r + 11'h1;
        end else begin
            busyRun_r <= '0;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // deselected for a while
    sequence s_idle;
        chipSelN [*6];
    endsequence
    // busy ends with no neighbour cycle behind it
    sequence s_timed_end;
        $fell(statusByte_r[0]) && !arrayBusy && !$past(arrayBusy, 4);
    endsequence

    property p_reserved_zero;
        statusByte_r[6:5] == 2'h0;
    endproperty
    property p_busy_follows;
        $rose(arrayBusy) |-> ##[1:3] statusByte_r[0];
    endproperty
    property p_done_clears;
        $rose(arrayOpDone) |-> ##[1:3] !statusByte_r[1];
    endproperty
    property p_whole_guard;
        launch_r.whole |-> $past(statusByte_r[3:2]) == 2'h0 && $past(statusByte_r[1]);
    endproperty
    property p_launch_deselect;
        launch_r.whole || launch_r.page || launch_r.sector |-> $past(chipSelN, 2);
    endproperty
    property p_idle_quiet;
        s_idle |-> !serialOutEn_r;
    endproperty
    property p_timed_length;
        s_timed_end |-> busyRun_r >= TW_CYC - 1 && busyRun_r <= TW_CYC + 1;
    endproperty
    property p_timed_wel;
        s_timed_end |-> ##[0:1] !statusByte_r[1];
    endproperty
    property p_start_needs_wel;
        $rose(statusByte_r[0]) && !arrayBusy && !$past(arrayBusy) |-> statusByte_r[1];
    endproperty
    property p_enable_selected;
        $rose(serialOutEn_r) |-> !$past(chipSelN, 3);
    endproperty

    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved status bits set");
    a_busy_follows: assert property (p_busy_follows)
        else $error("busy bit missed neighbour cycle");
    a_done_clears: assert property (p_done_clears)
        else $error("latch kept after cycle done");
    a_whole_guard: assert property (p_whole_guard)
        else $error("whole clear launched while guarded");
    a_launch_deselect: assert property (p_launch_deselect)
        else $error("launch without deselect");
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("output enabled while deselected");
    a_timed_length: assert property (p_timed_length)
        else $error("timed cycle length off");
    a_timed_wel: assert property (p_timed_wel)
        else $error("latch kept after timed cycle");
    a_start_needs_wel: assert property (p_start_needs_wel)
        else $error("timed cycle without latch");
    a_enable_selected: assert property (p_enable_selected)
        else $error("output enabled too early");
endmodule

//--- testbench/test_sfcfe_front_end.sv
// self-checking bench of the serial flash command front end
// assumes the host model drives spi and a stub answers array fetches
`timescale 1ns/1ns
`include "sfcfe_consts.svh"
module test_sfcfe_front_end import sfcfe_pkg::*;;
    localparam int TW_NS = 8000; // long enough to read status mid-cycle
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic writeProtectN = 1'b1;
    logic arrDataValid = 1'b0;
    logic arrayBusy = 1'b0;
    logic arrayOpDone = 1'b0;
    logic [7:0] arrData = 8'h00;
    logic chipSelN, sclk, serialIn, serialOut_r, serialOutEn_r;
    logic [7:0] statusByte_r, a, b;
    logic [23:0] pendAddr, e, launchAt;
    logic [63:0] rx;
    sfcfe_fetch_t fetch_r;
    sfcfe_launch_t launch_r;
    int fails = 0, testsRun = 0, wholeCnt = 0, wrCnt = 0, pend = 0, lag = 1;

    always #4 mclk = ~mclk;

    sfcfe_front_end #(.TW_NS(TW_NS), .FIFO_DEPTH(8)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .chipSelN(chipSelN), .sclk(sclk),
        .serialIn(serialIn), .writeProtectN(writeProtectN), .serialOut_r(serialOut_r),
        .serialOutEn_r(serialOutEn_r), .fetch_r(fetch_r), .arrDataValid(arrDataValid),
        .arrData(arrData), .arrayBusy(arrayBusy), .arrayOpDone(arrayOpDone),
        .launch_r(launch_r), .statusByte_r(statusByte_r));
    sfcfe_host_model i_host (.chipSelN(chipSelN), .sclk(sclk), .serialIn(serialIn),
        .serialOut_r(serialOut_r), .serialOutEn_r(serialOutEn_r));

    // array contents: a pattern that differs across the wrap point
    function automatic logic [7:0] arrByte(input logic [23:0] ad);
        return ad[7:0] ^ {6'h00, ad[17:16]} ^ 8'h3c;
    endfunction

    // array stub: one answer per fetch, lag cycles later
    always @(negedge mclk) begin
        arrDataValid = (fetch_r.valid !== 1'b1 && pend == 1);
        if (arrDataValid) arrData = arrByte(pendAddr);
        if (fetch_r.valid === 1'b1) begin
            pendAddr = fetch_r.addr;
            pend = lag;
        end else if (pend > 0) begin
            pend--;
        end
    end

    // count whole-array launches, and program or erase launches with their address
    always @(posedge mclk) begin
        if (launch_r.whole === 1'b1) wholeCnt++;
        if (launch_r.page === 1'b1 || launch_r.sector === 1'b1) begin
            wrCnt++;
            launchAt = launch_r.addr;
        end
    end

    task automatic closeOut;
        $display("counts: %0d compared, %0d bad", testsRun, fails);
        if (fails == 0 && testsRun > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        testsRun++;
        if (seen !== want) begin
            fails++;
            $display("BAD at %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic done(input string name);
        $display("test %s ended, %0d bad so far", name, fails);
    endtask

    task automatic spi(input logic [63:0] tx, input int n);
        i_host.xfer(tx, n, rx);
    endtask

    // status read with two repeated bytes
    task automatic rdStatus;
        spi({`SFCFE_OP_STAT_RD, 56'h0}, 24);
        a = rx[55:48];
        b = rx[47:40];
    endtask

    // bounded wait for the busy bit to drop
    task automatic waitIdle;
        repeat (8) @(negedge mclk);
        for (int n = 0; n < 1300 && statusByte_r[0] !== 1'b0; n++) @(negedge mclk);
        if (statusByte_r[0] !== 1'b0) begin
            fails++;
            closeOut;
        end
    endtask

    initial begin
        #800000;
        fails++;
        closeOut;
    end

    initial begin
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        repeat (8) @(negedge mclk);
        check(statusByte_r, 8'h00);
        rdStatus;
        check(a, 8'h00);
        check(b, 8'h00);
        done("reset");
        spi({`SFCFE_OP_ARM, 56'h0}, 8);
        rdStatus;
        check(a, 8'h02);
        check(b, 8'h02);
        spi({`SFCFE_OP_DISARM, 56'h0}, 8);
        rdStatus;
        check(a, 8'h00);
        // nine clocks: not on a byte boundary
        spi({`SFCFE_OP_ARM, 56'h0}, 9);
        rdStatus;
        check(a, 8'h00);
        spi({`SFCFE_OP_STAT_WR, 8'h8c, 48'h0}, 16);
        rdStatus;
        check(a, 8'h00);
        done("latch");
        spi({`SFCFE_OP_ARM, 56'h0}, 8);
        spi({`SFCFE_OP_STAT_WR, 8'hff, 48'h0}, 16);
        check(statusByte_r & 8'h03, 8'h03);
        rdStatus;
        check(a & 8'h03, 8'h03);
        waitIdle;
        check(statusByte_r, 8'h8c);
        done("status write");
        spi({`SFCFE_OP_ARM, 56'h0}, 8);
        spi({`SFCFE_OP_WHOLE, 56'h0}, 8);
        check(wholeCnt[7:0], 8'h00);
        @(negedge mclk) writeProtectN = 1'b0;
        spi({`SFCFE_OP_STAT_WR, 8'h00, 48'h0}, 16);
        check(statusByte_r, 8'h8e);
        // whole array guarded: an armed sector clear must not start
        spi({`SFCFE_OP_SECTOR, 24'h000000, 32'h0}, 32);
        check(wrCnt[7:0], 8'h00);
        @(negedge mclk) writeProtectN = 1'b1;
        spi({`SFCFE_OP_STAT_WR, 8'h00, 48'h0}, 16);
        waitIdle;
        check(statusByte_r, 8'h00);
        spi({`SFCFE_OP_ARM, 56'h0}, 8);
        spi({`SFCFE_OP_WHOLE, 56'h0}, 8);
        check(wholeCnt[7:0], 8'h01);
        // latch still set: a cut sector clear fails, a page write starts
        spi({`SFCFE_OP_SECTOR, 24'h030000, 8'h00, 24'h0}, 33);
        check(wrCnt[7:0], 8'h00);
        spi({`SFCFE_OP_PAGE, 24'h012345, 8'h77, 24'h0}, 40);
        check(wrCnt[7:0], 8'h01);
        check(launchAt[15:8], 8'h23);
        done("protect");
        @(negedge mclk) arrayBusy = 1'b1;
        rdStatus;
        check(a, 8'h03);
        spi({`SFCFE_OP_READ, 24'h000010, 32'h0}, 64);
        check(rx[31:24], 8'hxx);
        @(negedge mclk) arrayOpDone = 1'b1;
        @(negedge mclk) arrayOpDone = 1'b0;
        arrayBusy = 1'b0;
        repeat (4) @(negedge mclk);
        check(statusByte_r, 8'h00);
        done("busy");
        spi({`SFCFE_OP_READ, 24'h03fffe, 32'h0}, 64);
        for (int k = 0; k < 4; k++) begin
            e = 24'h03fffe + k;
            if (e > `SFCFE_ARRAY_TOP) e = e - `SFCFE_ARRAY_TOP - 24'h1;
            check(rx[31-8*k -: 8], arrByte(e));
        end
        lag = 3; // slow array for the fast read
        spi({`SFCFE_OP_FAST, 24'h000123, 8'h00, 24'h0}, 64);
        for (int k = 0; k < 3; k++) check(rx[23-8*k -: 8], arrByte(24'h000123 + k));
        done("reads");
        spi({`SFCFE_OP_WAKE_ID, 24'h0, 32'h0}, 64);
        for (int k = 0; k < 4; k++) check(rx[31-8*k -: 8], `SFCFE_PART_CODE);
        for (int s = 0; s < 2; s++) begin
            spi({`SFCFE_OP_MFG_ID, 16'h0, 8'(s), 32'h0}, 64);
            for (int k = 0; k < 4; k++) begin
                b = ((k + s) % 2 == 0) ? `SFCFE_MAKER_CODE : `SFCFE_PART_CODE;
                check(rx[31-8*k -: 8], b);
            end
        end
        done("identifier");
        closeOut;
    end
endmodule

bind sfcfe_front_end sfcfe_front_end_properties #(.TW_NS(TW_NS)) i_props (
    .mclk(mclk), .rst_n(rst_n), .chipSelN(chipSelN), .serialOutEn_r(serialOutEn_r),
    .arrayBusy(arrayBusy), .arrayOpDone(arrayOpDone), .launch_r(launch_r),
    .statusByte_r(statusByte_r));
